//--- auth_filter_map.vh
// register map, field positions and reset values of the blocked-port admission filter
`ifndef AUTH_FILTER_MAP_VH
`define AUTH_FILTER_MAP_VH
// printed offsets are register indexes; byte address is four times the index
`define IDX_GLOBAL_ALLOW 8'h00
`define IDX_MULTIPORT_ALLOW 8'h01
`define IDX_SUBNET_0 8'h02
`define IDX_SUBNET_1 8'h0A
// each 64-bit register is split into two words: mask word at index, value word at index+1
`define IDX_SUBNET_HI_OFS 8'h01
`define IDX_CHECK_MODE 8'h20
`define BIT_ALLOW_RARP 6
`define BIT_ALLOW_BPDU 5
`define BIT_ALLOW_RMC 4
`define BIT_ALLOW_DHCP 3
`define BIT_ALLOW_ARP 2
`define BIT_ALLOW_2SUB 1
`define GLOBAL_WMASK 8'hFF
`define MULTIPORT_WMASK 8'h3F
`define RST_GLOBAL_ALLOW 8'h00
`define RST_MULTIPORT_ALLOW 8'h00
`define RST_SUBNET 32'h00000000
`define RST_BLOCK_MODE 2'h0
`define BLOCK_MODE_INGRESS 2'h1
`define BLOCK_MODE_BOTH 2'h3
`define RMC_PREFIX 44'h0180C20000_0
`define RMC_LOW_ADDR 4'h2
`define RMC_RANGE_LO 4'h4
`endif

//--- port_auth_block_filter.v
// blocked-port frame admission filter with apb register file
//
// Added by the designer: register access over APB.
`include "auth_filter_map.vh"
`default_nettype none
// What this block does
// - the allow bits only affect frames on a port whose block mode is active.
// - allow bit 6 passes reverse address resolution frames on a blocked port, else drops.
// - allow bit 5 passes bridge protocol frames on a blocked port, else drops.
// - allow bit 4 passes destinations 01-80-C2-00-00-02 and -04 to -0F, else drops.
// - allow bit 3 passes host configuration frames on a blocked port, else drops.
// - allow bit 2 passes address resolution frames on a blocked port, else drops.
// - allow bit 1 passes frames whose destination ip is in either subnet, else drops.
// - multiport bit n (0 to 5) passes frames matching multiport entry n, else drops.
// - subnet register 0 holds value in bits 63:32 and mask in 31:0, both reset to zero.
// - subnet register 1 holds value in bits 63:32 and mask in 31:0, both reset to zero.
// - block mode 01 checks the ingress port and forwards only allowed classes.
// - block mode 11 also requires every egress port of the frame to be in block mode.
module port_auth_block_filter #(
  parameter NUM_PORTS = 8,
  parameter NUM_MPORT = 6
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frame_valid,
  input wire [2:0] frame_ingress_port,
  input wire [NUM_PORTS-1:0] frame_egress_map,
  input wire [47:0] frame_dest_mac,
  input wire [31:0] frame_dest_ip,
  input wire frame_dest_ip_valid,
  input wire frame_is_rarp,
  input wire frame_is_arp,
  input wire frame_is_dhcp,
  input wire frame_is_bpdu,
  input wire [NUM_MPORT-1:0] frame_mport_hit,
  output reg verdict_valid,
  output reg verdict_forward,
  output reg verdict_drop
);

////////////////////////////////////////////////////////////////////////////////
// register file

reg [7:0] global_allow_reg;
reg [7:0] multiport_allow_reg;
reg [31:0] subnet_value_reg [0:1];
reg [31:0] subnet_mask_reg [0:1];
reg [2*NUM_PORTS-1:0] block_mode_reg;

wire [9:0] word_index = paddr[11:2];
wire setup_access = psel & penable;
wire wr_en = setup_access & pwrite;

// word indexes on the bus; the byte address is four times the index
localparam [9:0] GLOBAL_WORD = {2'h0, `IDX_GLOBAL_ALLOW};
localparam [9:0] MPORT_WORD = {2'h0, `IDX_MULTIPORT_ALLOW};
localparam [9:0] MASK0_WORD = {2'h0, `IDX_SUBNET_0};
localparam [9:0] VALUE0_WORD = {2'h0, `IDX_SUBNET_0 + `IDX_SUBNET_HI_OFS};
localparam [9:0] MASK1_WORD = {2'h0, `IDX_SUBNET_1};
localparam [9:0] VALUE1_WORD = {2'h0, `IDX_SUBNET_1 + `IDX_SUBNET_HI_OFS};
localparam [9:0] MODE_WORD = {2'h0, `IDX_CHECK_MODE};

// single-cycle access phase: the slave never stalls
assign pready = 1'b1;

function [31:0] lane_merge;
  input [31:0] old_val;
  input [31:0] new_val;
  input [3:0] strb;
  integer k;
  begin
    lane_merge = old_val;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (strb[k])
      begin
        lane_merge[8*k +: 8] = new_val[8*k +: 8];
      end
    end
  end
endfunction

function is_mapped;
  input [9:0] idx;
  begin
    is_mapped = (idx == GLOBAL_WORD) ||
                (idx == MPORT_WORD) ||
                (idx == MASK0_WORD) ||
                (idx == VALUE0_WORD) ||
                (idx == MASK1_WORD) ||
                (idx == VALUE1_WORD) ||
                (idx == MODE_WORD);
  end
endfunction

assign pslverr = setup_access & ~is_mapped(word_index);

wire [31:0] global_merged = lane_merge({24'h000000, global_allow_reg}, pwdata, pstrb);
wire [31:0] mport_merged = lane_merge({24'h000000, multiport_allow_reg}, pwdata, pstrb);
wire [31:0] mode_merged = lane_merge({{(32-2*NUM_PORTS){1'b0}}, block_mode_reg}, pwdata,
  pstrb);

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    global_allow_reg <= `RST_GLOBAL_ALLOW;
    multiport_allow_reg <= `RST_MULTIPORT_ALLOW;
    block_mode_reg <= {NUM_PORTS{`RST_BLOCK_MODE}};
  end
  else if (wr_en)
  begin
    if (word_index == GLOBAL_WORD)
    begin
      global_allow_reg <= global_merged[7:0] & `GLOBAL_WMASK;
    end
    if (word_index == MPORT_WORD)
    begin
      multiport_allow_reg <= mport_merged[7:0] & `MULTIPORT_WMASK;
    end
    if (word_index == MODE_WORD)
    begin
      block_mode_reg <= mode_merged[2*NUM_PORTS-1:0];
    end
  end
end

// write strobes for the two subnet sets, decoded once per set
wire [1:0] mask_wr;
wire [1:0] value_wr;
genvar s;
generate
  for (s = 0; s < 2; s = s + 1)
  begin : g_subnet
    wire [9:0] mask_idx = (s == 0) ? MASK0_WORD : MASK1_WORD;
    wire [9:0] value_idx = (s == 0) ? VALUE0_WORD : VALUE1_WORD;
    assign mask_wr[s] = wr_en & (word_index == mask_idx);
    assign value_wr[s] = wr_en & (word_index == value_idx);
  end
endgenerate

// one process owns both sets, so every storage word keeps a single driver
integer n;
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    for (n = 0; n < 2; n = n + 1)
    begin
      subnet_value_reg[n] <= `RST_SUBNET;
      subnet_mask_reg[n] <= `RST_SUBNET;
    end
  end
  else
  begin
    for (n = 0; n < 2; n = n + 1)
    begin
      // low word carries the mask field, high word the subnet value
      if (mask_wr[n])
      begin
        subnet_mask_reg[n] <= lane_merge(subnet_mask_reg[n], pwdata, pstrb);
      end
      if (value_wr[n])
      begin
        subnet_value_reg[n] <= lane_merge(subnet_value_reg[n], pwdata, pstrb);
      end
    end
  end
end

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    prdata <= 32'h00000000;
  end
  else if (psel & ~penable & ~pwrite)
  begin
    case (word_index)
      GLOBAL_WORD: prdata <= {24'h000000, global_allow_reg};
      MPORT_WORD: prdata <= {24'h000000, multiport_allow_reg};
      MASK0_WORD: prdata <= subnet_mask_reg[0];
      VALUE0_WORD: prdata <= subnet_value_reg[0];
      MASK1_WORD: prdata <= subnet_mask_reg[1];
      VALUE1_WORD: prdata <= subnet_value_reg[1];
      MODE_WORD: prdata <= {{(32-2*NUM_PORTS){1'b0}}, block_mode_reg};
      default: prdata <= 32'h00000000;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// frame classification

function [1:0] mode_of;
  input [2*NUM_PORTS-1:0] modes;
  input [2:0] port;
  begin
    mode_of = modes[2*port +: 2];
  end
endfunction

function mode_active;
  input [1:0] mode;
  begin
    // the reserved code 10 is treated as not blocked
    mode_active = (mode == `BLOCK_MODE_INGRESS) || (mode == `BLOCK_MODE_BOTH);
  end
endfunction

wire [1:0] ingress_mode = mode_of(block_mode_reg, frame_ingress_port);

// reserved multicast: 01-80-C2-00-00-02 or the 04..0F range
wire rmc_prefix_hit = (frame_dest_mac[47:4] == `RMC_PREFIX);
wire rmc_hit = rmc_prefix_hit & ((frame_dest_mac[3:0] == `RMC_LOW_ADDR) |
  (frame_dest_mac[3:0] >= `RMC_RANGE_LO));

wire [1:0] subnet_hit;
generate
  for (s = 0; s < 2; s = s + 1)
  begin : g_match
    assign subnet_hit[s] = frame_dest_ip_valid &
      ((frame_dest_ip & subnet_mask_reg[s]) ==
       (subnet_value_reg[s] & subnet_mask_reg[s]));
  end
endgenerate

wire allow_reverse_addr_resolution = global_allow_reg[`BIT_ALLOW_RARP];
wire allow_bridge_protocol_frames = global_allow_reg[`BIT_ALLOW_BPDU];
wire allow_reserved_multicast = global_allow_reg[`BIT_ALLOW_RMC];
wire allow_host_config_frames = global_allow_reg[`BIT_ALLOW_DHCP];
wire allow_addr_resolution = global_allow_reg[`BIT_ALLOW_ARP];
wire allow_two_subnets = global_allow_reg[`BIT_ALLOW_2SUB];

wire class_allowed =
  (frame_is_rarp & allow_reverse_addr_resolution) |
  (frame_is_bpdu & allow_bridge_protocol_frames) |
  (rmc_hit & allow_reserved_multicast) |
  (frame_is_dhcp & allow_host_config_frames) |
  (frame_is_arp & allow_addr_resolution) |
  ((|subnet_hit) & allow_two_subnets) |
  (|(frame_mport_hit & multiport_allow_reg[NUM_MPORT-1:0]));

// every egress port named in the map must itself be in block mode
wire [NUM_PORTS-1:0] egress_blocked;
genvar p;
generate
  for (p = 0; p < NUM_PORTS; p = p + 1)
  begin : g_egress
    assign egress_blocked[p] = mode_active(block_mode_reg[2*p +: 2]);
  end
endgenerate
wire egress_ok = ((frame_egress_map & ~egress_blocked) == {NUM_PORTS{1'b0}});

// verdict by ingress block mode; the reserved code 10 falls to the open branch
reg pass_now;
always @*
begin
  case (ingress_mode)
    `BLOCK_MODE_INGRESS:
    begin
      pass_now = class_allowed;
    end
    `BLOCK_MODE_BOTH:
    begin
      pass_now = class_allowed & egress_ok;
    end
    default:
    begin
      pass_now = 1'b1;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// registered verdict, one cycle after the frame is presented

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    verdict_valid <= 1'b0;
    verdict_forward <= 1'b0;
    verdict_drop <= 1'b0;
  end
  else
  begin
    verdict_valid <= frame_valid;
    verdict_forward <= frame_valid & pass_now;
    verdict_drop <= frame_valid & ~pass_now;
  end
end

endmodule
`default_nettype wire

//--- auth_filter_properties.sv
// port-level assertions for the blocked-port admission filter
`default_nettype none
module auth_filter_properties #(parameter NUM_PORTS = 8, parameter NUM_MPORT = 6) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire frame_valid,
  input wire [2:0] frame_ingress_port,
  input wire [47:0] frame_dest_mac,
  input wire frame_dest_ip_valid,
  input wire frame_is_rarp,
  input wire frame_is_arp,
  input wire frame_is_dhcp,
  input wire frame_is_bpdu,
  input wire [NUM_MPORT-1:0] frame_mport_hit,
  input wire verdict_valid,
  input wire verdict_forward,
  input wire verdict_drop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mode_reg;
  logic [1:0] ing_mode;
  logic no_class;
  // shadow of the block modes; only full-width writes are followed
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      mode_reg <= 16'h0000;
    else if (psel && penable && pwrite && paddr[11:2] == 10'h020 && pstrb[1:0] == 2'h3)
      mode_reg <= pwdata[15:0];
  assign ing_mode = mode_reg[2*frame_ingress_port +: 2];
  assign no_class = !(frame_is_rarp || frame_is_arp || frame_is_dhcp || frame_is_bpdu
    || frame_dest_ip_valid || (|frame_mport_hit) || frame_dest_mac[47:40] == 8'h01);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence open_frame_s;
    frame_valid && !ing_mode[0];
  endsequence
  sequence bare_block_s;
    frame_valid && ing_mode[0] && no_class;
  endsequence
  verdict_follows_a: assert property (frame_valid |=> verdict_valid)
    else $error("frame without verdict");
  verdict_alone_a: assert property (!frame_valid |=> !verdict_valid)
    else $error("verdict without frame");
  one_outcome_a: assert property (verdict_valid |-> verdict_forward != verdict_drop)
    else $error("verdict not exactly one outcome");
  quiet_idle_a: assert property (!verdict_valid |-> !verdict_forward && !verdict_drop)
    else $error("outcome outside verdict");
  open_pass_a: assert property (open_frame_s |=> verdict_forward)
    else $error("unblocked port frame dropped");
  bare_drop_a: assert property (bare_block_s |=> verdict_drop)
    else $error("unclassified blocked frame forwarded");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  err_hole_a: assert property (psel && penable && paddr[11:2] == 10'h3FF |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind port_auth_block_filter auth_filter_properties #(.NUM_PORTS(NUM_PORTS),
  .NUM_MPORT(NUM_MPORT)) props (.*);
`default_nettype wire

//--- ingress_parser_model.sv
// switch ingress parser model presenting classified frames
`default_nettype none
module ingress_parser_model (
  input wire clk,
  output logic frame_valid,
  output logic [2:0] port,
  output logic [7:0] egr,
  output logic [47:0] mac,
  output logic [31:0] ip,
  output logic [4:0] cls,
  output logic [5:0] mp
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {frame_valid, port, egr, mac, ip, cls, mp} = '0;
  end
  task send(input [2:0] pt, input [7:0] eg, input [47:0] m, input [31:0] a, input [4:0] c,
    input [5:0] h);
    @(posedge clk);
    frame_valid <= 1'b1;
    {port, egr, mac, ip, cls, mp} <= {pt, eg, m, a, c, h};
    @(posedge clk);
    frame_valid <= 1'b0;
    // released fields flip so a stale value never passes for a live one
    {mac, ip, cls, mp} <= ~{m, a, c, h};
  endtask
endmodule
`default_nettype wire

//--- port_auth_block_filter_test.sv
// self-checking bench for the blocked-port admission filter
`default_nettype none
module port_auth_block_filter_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, fv, vv, vf, vd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ip;
  logic [31:0] fip = 32'hC0A80155;
  logic [2:0] port;
  logic [7:0] egr;
  logic [47:0] mac;
  logic [4:0] cls;
  logic [5:0] mp;
  logic [11:0] adr [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h028, 12'h02C, 12'h080};
  logic [31:0] wv [7] = '{32'hFF, 32'hFF, 32'hFFFFFF00, 32'hC0A80100, 32'hFFFF0000,
    32'h0A0B0000, 32'hFFFF};
  int pos [4] = '{2, 3, 5, 6};
  int n_errors = 0, tests_run = 0, cycles = 0;
  ingress_parser_model p (.clk(clk), .frame_valid(fv), .port(port), .egr(egr), .mac(mac),
    .ip(ip), .cls(cls), .mp(mp));
  port_auth_block_filter DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(fv), .frame_ingress_port(port),
    .frame_egress_map(egr), .frame_dest_mac(mac), .frame_dest_ip(ip),
    .frame_dest_ip_valid(cls[4]), .frame_is_rarp(cls[3]), .frame_is_arp(cls[0]),
    .frame_is_dhcp(cls[1]), .frame_is_bpdu(cls[2]), .frame_mport_hit(mp),
    .verdict_valid(vv), .verdict_forward(vf), .verdict_drop(vd));
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      test_done;
    end
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", exp, rd);
  endtask
  task frm(input [7:0] eg, input [47:0] m, input [4:0] c, input [5:0] h, input f);
    p.send(3'h0, eg, m, fip, c, h);
    #1;
    chk("verdict", {1'b1, f, !f}, {vv, vf, vd});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdchk(adr[i], 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, adr[i], wv[i]);
      rdchk(adr[i], i == 1 ? 32'h3F : wv[i]);
    end
    apb(1'b1, 12'hFFC, 32'h1);
    chk("unmapped error", 32'h1, err);
    rdchk(12'hFFC, 32'h0);
    $display("test registers done");
    apb(1'b1, 12'h080, 32'h0);
    frm(8'h02, 48'h0, 5'h0, 6'h0, 1'b1);
    apb(1'b1, 12'h080, 32'h2);
    frm(8'h02, 48'h0, 5'h0, 6'h0, 1'b1);
    apb(1'b1, 12'h080, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    frm(8'h02, 48'h0, 5'h0, 6'h0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 12'h000, 32'h0);
      frm(8'h02, 48'h0, 5'(1 << i), 6'h0, 1'b0);
      apb(1'b1, 12'h000, 32'(1 << pos[i]));
      frm(8'h02, 48'h0, 5'(1 << i), 6'h0, 1'b1);
    end
    apb(1'b1, 12'h000, 32'h10);
    frm(8'h02, 48'h0180C2000002, 5'h0, 6'h0, 1'b1);
    frm(8'h02, 48'h0180C200000F, 5'h0, 6'h0, 1'b1);
    frm(8'h02, 48'h0180C2000003, 5'h0, 6'h0, 1'b0);
    apb(1'b1, 12'h000, 32'h2);
    frm(8'h02, 48'h0180C2000004, 5'h0, 6'h0, 1'b0);
    frm(8'h02, 48'h0, 5'h10, 6'h0, 1'b1);
    fip = 32'h0A0B1234;
    frm(8'h02, 48'h0, 5'h10, 6'h0, 1'b1);
    fip = 32'h0A0C1234;
    frm(8'h02, 48'h0, 5'h10, 6'h0, 1'b0);
    fip = 32'hC0A80155;
    apb(1'b1, 12'h000, 32'h0);
    frm(8'h02, 48'h0, 5'h10, 6'h0, 1'b0);
    apb(1'b1, 12'h004, 32'h20);
    frm(8'h02, 48'h0, 5'h0, 6'h20, 1'b1);
    apb(1'b1, 12'h004, 32'h1F);
    frm(8'h02, 48'h0, 5'h0, 6'h20, 1'b0);
    $display("test blocked classes done");
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h080, 32'h3);
    frm(8'h02, 48'h0, 5'h1, 6'h0, 1'b0);
    apb(1'b1, 12'h080, 32'h7);
    frm(8'h02, 48'h0, 5'h1, 6'h0, 1'b1);
    $display("test egress check done");
    test_done;
  end
endmodule
`default_nettype wire
